/* File: rtl/fcs_top.sv */
// Purpose: Host sequencer that issues flash commands and polls their status.
// Assumes: Software programs address and data before writing an operation.
// Notes: One operation runs at a time; a start while busy is refused.
// Contract
// - Plain read needs no command cycles
// - All command cycles are writes except reads
// - Unlock AA at 555, then 55 at 2AA
// - Upper address bits ignored in command cycles
// - Write F0 to leave identification or fail
// - Program: unlock, A0, then datum at address
// - Erase: unlock, 80, unlock, 10 or 30
// - Identification: unlock, 90, then one read
// - Erase suspend is one B0 write
// - Take data only from next read after poll
// - Recheck poll bit after timeout bit sets
// - Sector additions within a 50 us window
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module fcs_top
  import fcs_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Software register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Flash pins.
  output logic [AW-1:0] fl_addr,
  output logic [DW-1:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [DW-1:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  input wire logic ready_busy_out
);

  typedef enum logic [3:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_PWAIT, S_VERIFY, S_VWAIT, S_FAIL, S_FWAIT
  } fcs_st_t;

  typedef struct packed {
    logic [AW-1:0] a;
    logic [DW-1:0] d;
    logic wr;
    logic last;
  } fcs_step_t;

  typedef struct packed {
    fcs_st_t st;
    fcs_op_t op;
    logic [2:0] idx;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [DW-1:0] res;
    logic busy;
    logic done;
    logic fail;
    logic refused;
    logic recheck;
    logic tog_v;
    logic tog_prev;
    logic toggling;
    logic [WIN_W-1:0] win;
    logic rdy_s1;
    logic rdy_s2;
    logic req;
    logic cwr;
    logic [AW-1:0] caddr;
    logic [DW-1:0] cdata;
    logic [31:0] rdata;
  } fcs_top_t;

  localparam fcs_top_t TOP_RST = '{st: S_IDLE, op: OP_NONE, rdy_s1: 1'b1,
                                   rdy_s2: 1'b1, default: '0};

  function automatic logic unlocked(input fcs_op_t op);
    return op inside {OP_ID, OP_PROG, OP_CHIP, OP_SECT};
  endfunction

  // Cycle i of operation op; upper command address bits stay zero.
  function automatic fcs_step_t step(input fcs_op_t op, input logic [2:0] i,
                                     input logic [AW-1:0] a, input logic [DW-1:0] d);
    fcs_step_t s;
    s = '{a: CMD_A1, d: D_UNL1, wr: 1'b1, last: 1'b0};
    if (i == 3'h1 || (i == 3'h4 && op inside {OP_CHIP, OP_SECT})) begin
      s.a = CMD_A2;
      s.d = D_UNL2;
    end
    case (op)
      OP_READ: s = '{a: a, d: 8'h00, wr: 1'b0, last: 1'b1};
      OP_RESET: s = '{a: ANY_A, d: D_RST, wr: 1'b1, last: 1'b1};
      OP_SUSP: s = '{a: ANY_A, d: D_SUSP, wr: 1'b1, last: 1'b1};
      OP_RESUME: s = '{a: ANY_A, d: D_RESUME, wr: 1'b1, last: 1'b1};
      OP_ADDS: s = '{a: a, d: D_SECT, wr: 1'b1, last: 1'b1};
      OP_PROG: begin
        if (i == 3'h2) s.d = D_PROG;
        if (i == 3'h3) s = '{a: a, d: d, wr: 1'b1, last: 1'b1};
      end
      OP_ID: begin
        if (i == 3'h2) s.d = D_ID;
        if (i == 3'h3) s = '{a: {a[AW-1:8], 6'h00, a[1:0]}, d: 8'h00, wr: 1'b0, last: 1'b0};
        if (i == 3'h4) s = '{a: ANY_A, d: D_RST, wr: 1'b1, last: 1'b1};
      end
      OP_CHIP, OP_SECT: begin
        if (i == 3'h2) s.d = D_ERASE;
        if (i == 3'h5 && op == OP_CHIP) s = '{a: CMD_A1, d: D_CHIP, wr: 1'b1, last: 1'b1};
        if (i == 3'h5 && op == OP_SECT) s = '{a: a, d: D_SECT, wr: 1'b1, last: 1'b1};
      end
      default: s.last = 1'b1;
    endcase
    return s;
  endfunction

  fcs_top_t s_ff;
  fcs_top_t nxt_s;
  fcs_cyc_if cyc();
  fcs_step_t cur;
  fcs_op_t wr_op;
  logic poll_hit;
  logic tog_stop;
  logic [31:0] stat;

  assign wr_op = fcs_op_t'(reg_wdata[3:0]);

  always_comb begin
    cur = step(s_ff.op, s_ff.idx, s_ff.addr, s_ff.data);
    poll_hit = cyc.rdata[POLL_BIT] ==
               ((s_ff.op == OP_PROG) ? s_ff.data[POLL_BIT] : 1'b1);
    // An unchanged toggle bit means the device went back to plain reads.
    tog_stop = s_ff.tog_v && (cyc.rdata[TOG_BIT] == s_ff.tog_prev);
    stat = 32'h00000000;
    stat[ST_BUSY] = s_ff.busy;
    stat[ST_DONE] = s_ff.done;
    stat[ST_FAIL] = s_ff.fail;
    stat[ST_REFUSED] = s_ff.refused;
    stat[ST_WIN] = s_ff.win != '0;
    stat[ST_RDY] = s_ff.rdy_s2;
    stat[ST_TOG] = s_ff.toggling;
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.req = 1'b0;
    nxt_s.rdata = 32'h00000000;
    nxt_s.rdy_s1 = ready_busy_out;
    nxt_s.rdy_s2 = s_ff.rdy_s1;
    if (s_ff.win != '0) nxt_s.win = s_ff.win - 1'b1;
    if (reg_rd) begin
      case (reg_addr)
        R_CTRL: nxt_s.rdata = {28'h0000000, s_ff.op};
        R_ADDR: nxt_s.rdata = {10'h000, s_ff.addr};
        R_DATA: nxt_s.rdata = {24'h000000, s_ff.data};
        R_STAT: nxt_s.rdata = stat;
        R_RES: nxt_s.rdata = {24'h000000, s_ff.res};
        default: nxt_s.rdata = 32'h00000000;
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        R_ADDR: if (!s_ff.busy) nxt_s.addr = reg_wdata[AW-1:0];
        R_DATA: if (!s_ff.busy) nxt_s.data = reg_wdata[DW-1:0];
        R_CTRL: begin
          // A late sector addition would start a fresh command instead.
          if (s_ff.busy || wr_op == OP_NONE || wr_op > OP_RESUME ||
              (wr_op == OP_ADDS && s_ff.win == '0)) begin
            nxt_s.refused = 1'b1;
          end else begin
            nxt_s.op = wr_op;
            nxt_s.idx = 3'h0;
            nxt_s.busy = 1'b1;
            nxt_s.done = 1'b0;
            nxt_s.fail = 1'b0;
            nxt_s.refused = 1'b0;
            nxt_s.recheck = 1'b0;
            nxt_s.tog_v = 1'b0;
            nxt_s.toggling = 1'b0;
            nxt_s.st = (wr_op == OP_POLL) ? S_POLL : S_ISSUE;
            if (!(wr_op inside {OP_READ, OP_POLL, OP_ADDS})) nxt_s.win = '0;
          end
        end
        default: ;
      endcase
    end
    case (s_ff.st)
      S_IDLE: ;
      S_ISSUE: begin
        nxt_s.req = 1'b1;
        nxt_s.cwr = cur.wr;
        nxt_s.caddr = cur.a;
        nxt_s.cdata = cur.d;
        nxt_s.st = S_WAIT;
      end
      S_WAIT: begin
        if (cyc.ack) begin
          if (!s_ff.cwr) nxt_s.res = cyc.rdata;
          nxt_s.idx = s_ff.idx + 3'h1;
          nxt_s.st = S_ISSUE;
          if (cur.last) begin
            if (s_ff.op inside {OP_SECT, OP_ADDS}) nxt_s.win = WIN_CYC - WIN_LEAD;
            if (s_ff.op inside {OP_PROG, OP_CHIP, OP_SUSP}) begin
              nxt_s.st = S_POLL;
            end else begin
              nxt_s.st = S_IDLE;
              nxt_s.busy = 1'b0;
              nxt_s.done = 1'b1;
            end
          end
        end
      end
      S_POLL: begin
        nxt_s.req = 1'b1;
        nxt_s.cwr = 1'b0;
        nxt_s.caddr = s_ff.addr;
        nxt_s.st = S_PWAIT;
      end
      S_PWAIT: begin
        if (cyc.ack) begin
          nxt_s.res = cyc.rdata;
          nxt_s.tog_v = 1'b1;
          nxt_s.tog_prev = cyc.rdata[TOG_BIT];
          nxt_s.toggling = s_ff.tog_v && !tog_stop;
          if (poll_hit) begin
            nxt_s.st = S_VERIFY;
          end else if (tog_stop) begin
            nxt_s.st = S_FAIL;
          end else if (cyc.rdata[FAIL_BIT] && s_ff.recheck) begin
            nxt_s.st = S_FAIL;
          end else begin
            nxt_s.recheck = cyc.rdata[FAIL_BIT];
            nxt_s.st = S_POLL;
          end
        end
      end
      S_VERIFY: begin
        nxt_s.req = 1'b1;
        nxt_s.cwr = 1'b0;
        nxt_s.caddr = s_ff.addr;
        nxt_s.st = S_VWAIT;
      end
      S_VWAIT: begin
        if (cyc.ack) begin
          nxt_s.res = cyc.rdata;
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.st = S_IDLE;
        end
      end
      S_FAIL: begin
        nxt_s.req = 1'b1;
        nxt_s.cwr = 1'b1;
        nxt_s.caddr = ANY_A;
        nxt_s.cdata = D_RST;
        nxt_s.st = S_FWAIT;
      end
      S_FWAIT: begin
        if (cyc.ack) begin
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
          nxt_s.fail = 1'b1;
          nxt_s.st = S_IDLE;
        end
      end
      default: nxt_s.st = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) s_ff <= TOP_RST;
    else s_ff <= nxt_s;
  end

  assign cyc.req = s_ff.req;
  assign cyc.wr = s_ff.cwr;
  assign cyc.addr = s_ff.caddr;
  assign cyc.wdata = s_ff.cdata;
  assign reg_rdata = s_ff.rdata;

  fcs_cycle u_cycle (
    .ref_clk(ref_clk),
    .rst(rst),
    .cyc(cyc),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  unlock_first_a:
  assert property ((s_ff.req && s_ff.idx == 3'h0 && unlocked(s_ff.op)) |->
                   (s_ff.caddr == CMD_A1 && s_ff.cdata == D_UNL1 && s_ff.cwr))
    else $error("first unlock cycle wrong");
  unlock_second_a:
  assert property ((s_ff.req && s_ff.idx == 3'h1 && unlocked(s_ff.op)) |->
                   (s_ff.caddr == CMD_A2 && s_ff.cdata == D_UNL2))
    else $error("second unlock cycle wrong");
  cmd_upper_a:
  assert property ((s_ff.req && s_ff.cwr && s_ff.caddr != s_ff.addr) |->
                   s_ff.caddr[AW-1:11] == 11'h000)
    else $error("command address upper bits not zero");
  prog_cycle_a:
  assert property ((s_ff.req && s_ff.op == OP_PROG && s_ff.idx == 3'h3) |->
                   (s_ff.cwr && s_ff.caddr == s_ff.addr && s_ff.cdata == s_ff.data))
    else $error("program target cycle wrong");
  erase_last_a:
  assert property ((s_ff.req && s_ff.op == OP_CHIP && s_ff.idx == 3'h5) |->
                   (s_ff.caddr == CMD_A1 && s_ff.cdata == D_CHIP))
    else $error("chip erase code wrong");
  id_read_a:
  assert property ((s_ff.req && s_ff.op == OP_ID && s_ff.idx == 3'h3) |->
                   !s_ff.cwr ##[6:20] (s_ff.req && s_ff.cwr && s_ff.cdata == D_RST))
    else $error("identification read or exit wrong");
  suspend_code_a:
  assert property ((s_ff.req && s_ff.op == OP_SUSP && s_ff.st == S_WAIT) |->
                   (s_ff.cwr && s_ff.cdata == D_SUSP))
    else $error("suspend code wrong");
  fail_reset_a:
  assert property ($rose(s_ff.st == S_FWAIT) |-> (s_ff.req && s_ff.cdata == D_RST))
    else $error("fail path did not write reset");
  verify_read_a:
  assert property ((s_ff.st == S_PWAIT && cyc.ack && poll_hit) |=>
                   s_ff.st == S_VERIFY ##1 (s_ff.req && !s_ff.cwr && s_ff.caddr == s_ff.addr))
    else $error("no verify read after poll hit");
  recheck_a:
  assert property ((s_ff.st == S_PWAIT && cyc.ack && !poll_hit && !tog_stop &&
                    cyc.rdata[FAIL_BIT] && !s_ff.recheck) |=>
                   (s_ff.st == S_POLL && s_ff.recheck && !s_ff.fail))
    else $error("timeout bit not rechecked");
  window_a:
  assert property ((reg_wr && reg_addr == R_CTRL && wr_op == OP_ADDS && s_ff.win == '0)
                   |=> s_ff.refused)
    else $error("late sector addition accepted");
  plain_read_a:
  assert property ((reg_wr && reg_addr == R_CTRL && wr_op == OP_READ && !s_ff.busy)
                   |=> ##1 (s_ff.req && !s_ff.cwr && s_ff.caddr == s_ff.addr))
    else $error("plain read not issued directly");

  prog_done_c: cover property (s_ff.op == OP_PROG && $fell(s_ff.busy) && !s_ff.fail);
  erase_done_c: cover property (s_ff.op == OP_CHIP && $fell(s_ff.busy));
  fail_c: cover property ($rose(s_ff.fail));
  add_sector_c: cover property (s_ff.op == OP_ADDS && $fell(s_ff.busy));

endmodule

/* File: rtl/fcs_pkg.sv */
// Purpose: Shared constants and types for the flash command sequencer host.
// Assumes: ref_clk runs at 10 MHz.
// Notes: Command addresses carry zeros above bit 10.
package fcs_pkg;

  localparam int AW = 22;
  localparam int DW = 8;
  localparam int CLK_NS = 100;

  // Rounds a least time up to whole clock cycles.
  function automatic int ns_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  localparam int T_ACC_NS = 70;
  localparam int T_WE_NS = 100;
  localparam int T_WIN_NS = 50000;
  localparam int SYNC_CYC = 2;
  localparam logic [3:0] RD_CYC = 4'(ns_up(T_ACC_NS) + SYNC_CYC);
  localparam logic [3:0] WR_CYC = 4'(ns_up(T_WE_NS));
  // The acceptance window is a longest time, so it rounds down.
  localparam int WIN_W = 10;
  localparam logic [WIN_W-1:0] WIN_CYC = WIN_W'(T_WIN_NS / CLK_NS);
  // The host count starts two cycles behind the strobe, and an addition needs a few more
  // cycles to reach the pins, so the host gives up this margin to stay inside the window.
  localparam logic [WIN_W-1:0] WIN_LEAD = WIN_W'(8);

  localparam logic [AW-1:0] CMD_A1 = 22'h000555;
  localparam logic [AW-1:0] CMD_A2 = 22'h0002aa;
  localparam logic [AW-1:0] ANY_A = 22'h000000;
  localparam logic [DW-1:0] D_UNL1 = 8'haa;
  localparam logic [DW-1:0] D_UNL2 = 8'h55;
  localparam logic [DW-1:0] D_PROG = 8'ha0;
  localparam logic [DW-1:0] D_ERASE = 8'h80;
  localparam logic [DW-1:0] D_CHIP = 8'h10;
  localparam logic [DW-1:0] D_SECT = 8'h30;
  localparam logic [DW-1:0] D_RESUME = 8'h30;
  localparam logic [DW-1:0] D_ID = 8'h90;
  localparam logic [DW-1:0] D_RST = 8'hf0;
  localparam logic [DW-1:0] D_SUSP = 8'hb0;

  localparam int POLL_BIT = 7;
  localparam int TOG_BIT = 6;
  localparam int FAIL_BIT = 5;

  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_ADDR = 8'h04;
  localparam logic [7:0] R_DATA = 8'h08;
  localparam logic [7:0] R_STAT = 8'h0c;
  localparam logic [7:0] R_RES = 8'h10;

  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_WIN = 4;
  localparam int ST_RDY = 5;
  localparam int ST_TOG = 6;

  typedef enum logic [3:0] {
    OP_NONE, OP_READ, OP_RESET, OP_ID, OP_PROG, OP_CHIP,
    OP_SECT, OP_ADDS, OP_POLL, OP_SUSP, OP_RESUME
  } fcs_op_t;

endpackage

/* File: rtl/fcs_cyc_if.sv */
// Purpose: Carries one bus cycle request and its answer.
// Assumes: req is a one-cycle pulse issued only while no cycle runs.
// Notes: ack is a one-cycle pulse; rdata holds until the next read.
`timescale 1ns/1ps
interface fcs_cyc_if;
  import fcs_pkg::*;
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic ack;
  logic [DW-1:0] rdata;
  modport seq (output req, wr, addr, wdata, input ack, rdata);
  modport eng (input req, wr, addr, wdata, output ack, rdata);
endinterface

/* File: rtl/fcs_cycle.sv */
// Purpose: Drives one read or write cycle on the flash pins.
// Assumes: The flash needs address and data stable across each strobe.
// Notes: Read data pass two flip-flops before capture.
`timescale 1ns/1ps
module fcs_cycle
  import fcs_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Sequencer side.
  fcs_cyc_if.eng cyc,
  // Flash pins.
  output logic [AW-1:0] fl_addr,
  output logic [DW-1:0] fl_dq_o,
  output logic fl_dq_oe,
  input wire logic [DW-1:0] fl_dq_i,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fcs_est_t;

  typedef struct packed {
    fcs_est_t st;
    logic [3:0] cnt;
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] dout;
    logic doe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic ack;
    logic [DW-1:0] rdata;
    logic [DW-1:0] dq_s1;
    logic [DW-1:0] dq_s2;
  } fcs_eng_t;

  localparam fcs_eng_t ENG_RST = '{st: E_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                   default: '0};

  fcs_eng_t e_ff;
  fcs_eng_t nxt_e;

  always_comb begin
    nxt_e = e_ff;
    nxt_e.ack = 1'b0;
    nxt_e.dq_s1 = fl_dq_i;
    nxt_e.dq_s2 = e_ff.dq_s1;
    case (e_ff.st)
      E_IDLE: begin
        if (cyc.req) begin
          nxt_e.st = E_SETUP;
          nxt_e.wr = cyc.wr;
          nxt_e.addr = cyc.addr;
          nxt_e.dout = cyc.wdata;
          nxt_e.doe = cyc.wr;
          nxt_e.ce_n = 1'b0;
          nxt_e.cnt = cyc.wr ? WR_CYC : RD_CYC;
        end
      end
      E_SETUP: begin
        nxt_e.st = E_STROBE;
        nxt_e.we_n = !e_ff.wr;
        nxt_e.oe_n = e_ff.wr;
      end
      E_STROBE: begin
        // Address and data stay put through the rising strobe edge.
        if (e_ff.cnt == 4'h1) begin
          nxt_e.st = E_HOLD;
          nxt_e.we_n = 1'b1;
          nxt_e.oe_n = 1'b1;
          if (!e_ff.wr) nxt_e.rdata = e_ff.dq_s2;
        end else begin
          nxt_e.cnt = e_ff.cnt - 4'h1;
        end
      end
      E_HOLD: begin
        nxt_e.st = E_IDLE;
        nxt_e.ce_n = 1'b1;
        nxt_e.doe = 1'b0;
        nxt_e.ack = 1'b1;
      end
      default: nxt_e.st = E_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) e_ff <= ENG_RST;
    else e_ff <= nxt_e;
  end

  assign cyc.ack = e_ff.ack;
  assign cyc.rdata = e_ff.rdata;
  assign fl_addr = e_ff.addr;
  assign fl_dq_o = e_ff.dout;
  assign fl_dq_oe = e_ff.doe;
  assign fl_ce_n = e_ff.ce_n;
  assign fl_we_n = e_ff.we_n;
  assign fl_oe_n = e_ff.oe_n;

endmodule

/* File: bench/fcs_flash_model.sv */
// Purpose: Behavioural flash device that answers the sequencer's pins.
// Assumes: Program and erase times are shortened; one sector group is protected.
// Notes: A released data line shows the inverse of its last value.
`timescale 1ns/1ps
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] MAKER = 8'h5e, // Arbitrary value.
  parameter logic [7:0] PART = 8'hc3, // Arbitrary value.
  parameter logic [3:0] PROT_GRP = 4'hf,
  parameter int PROG_NS = 10000,
  parameter int ERASE_NS = 20000
) (
  // Pins from the host.
  input wire logic [AW-1:0] fl_addr,
  input wire logic [DW-1:0] dq_bus,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  // Pins to the host.
  output logic [DW-1:0] dq_out,
  output logic ready_busy_out
);
  typedef enum {m_rd, m_id, m_prg, m_ers, m_win, m_sus, m_sprg} fcs_mode_t;
  fcs_mode_t md = m_rd;
  fcs_mode_t idb = m_rd;
  logic [7:0] mem [logic [AW-1:0]];
  logic [63:0] ers = '0;
  logic [AW-1:0] a_lat;
  logic [AW-1:0] pa;
  logic [7:0] pd;
  logic tog = 1'b0;
  logic chip = 1'b0;
  // A program to an unprotected address that tries to raise a cleared bit never finishes and flags a timeout.
  logic tmo = 1'b0;
  int s = 0;
  int bad_cnt = 0;
  realtime t_end;
  realtime rem;
  initial dq_out = 8'h00;
  // Busy also covers the sector acceptance window, so the host never sees ready too early.
  assign ready_busy_out = !(md inside {m_prg, m_sprg, m_ers, m_win});

  function automatic logic [7:0] rd(input logic [AW-1:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  function automatic logic prot(input logic [AW-1:0] a);
    return a[21:18] == PROT_GRP;
  endfunction

  always @(negedge fl_oe_n) begin
    if (!fl_ce_n) begin
      if (md inside {m_prg, m_sprg, m_ers, m_win}) tog = ~tog;
      case (md)
        m_id: dq_out = fl_addr[1:0] == 2'd0 ? MAKER : fl_addr[1:0] == 2'd1 ? PART :
                       {7'h00, prot(fl_addr)};
        m_prg, m_sprg: dq_out = {~pd[7], tog, tmo, 5'h00};
        m_ers, m_win: dq_out = {1'b0, tog, 6'h00};
        m_sus: dq_out = ers[fl_addr[21:16]] ? {1'b1, tog, 6'h00} : rd(fl_addr);
        default: dq_out = rd(fl_addr);
      endcase
    end
  end

  always @(posedge fl_oe_n) dq_out = ~dq_out;

  always @(negedge fl_we_n) a_lat = fl_addr;

  always @(posedge fl_we_n) begin
    if (!fl_ce_n) wr(a_lat, dq_bus);
  end

  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    logic [10:0] c;
    logic ok;
    c = a[10:0];
    ok = 1'b1;
    if (md inside {m_prg, m_sprg, m_ers} && !(tmo && d == 8'hf0)) begin
      if (md == m_ers && d == 8'hb0 && !chip) begin
        rem = t_end - $realtime;
        md = m_sus;
      end
    end else if (md == m_win && d inside {8'h30, 8'hb0}) begin
      if (d == 8'h30) begin
        ers[a[21:16]] = 1'b1;
        t_end = $realtime + 50000;
      end else begin
        rem = ERASE_NS;
        md = m_sus;
      end
    end else if (md == m_sus && s == 0 && d == 8'h30) begin
      md = m_ers;
      t_end = $realtime + rem;
    end else if (d == 8'hf0) begin
      s = 0;
      tmo = 1'b0;
      md = md == m_id ? idb : md == m_sus ? m_sus : m_rd;
    end else begin
      if (md == m_win) begin
        md = m_rd;
        ers = '0;
      end
      case (s)
        0, 3: ok = c == 11'h555 && d == 8'haa;
        1, 4: ok = c == 11'h2aa && d == 8'h55;
        2: ok = c == 11'h555 && d inside {8'ha0, 8'h80, 8'h90};
        5: ok = md != m_sus && ((c == 11'h555 && d == 8'h10) || d == 8'h30);
        default: ok = 1'b1;
      endcase
      if (!ok) begin
        bad_cnt++;
        s = 0;
      end else if (s == 2 && d == 8'h90) begin
        s = 0;
        idb = md;
        md = m_id;
      end else if (s == 2) begin
        s = d == 8'ha0 ? 6 : 3;
      end else if (s == 5) begin
        s = 0;
        chip = d == 8'h10;
        ers = chip ? '1 : 64'h0;
        ers[a[21:16]] = 1'b1;
        md = chip ? m_ers : m_win;
        t_end = $realtime + (chip ? ERASE_NS : 50000);
      end else if (s == 6) begin
        s = 0;
        pa = a;
        pd = d;
        tmo = !prot(a) && ((d & ~rd(a)) != 8'h00);
        md = md == m_sus ? m_sprg : m_prg;
        t_end = $realtime + (prot(a) ? 2000 : PROG_NS);
      end else begin
        s++;
      end
    end
  endtask

  always #100 begin
    logic [AW-1:0] q [$];
    if (md inside {m_prg, m_sprg, m_ers, m_win} && $realtime >= t_end && !tmo) begin
      if (md == m_win) begin
        md = m_ers;
        t_end = $realtime + ERASE_NS;
      end else if (md == m_ers) begin
        q.delete();
        foreach (mem[k]) if (ers[k[21:16]] && !prot(k)) q.push_back(k);
        foreach (q[i]) mem.delete(q[i]);
        ers = '0;
        md = m_rd;
      end else begin
        if (!prot(pa)) mem[pa] = pd & rd(pa);
        md = md == m_sprg ? m_sus : m_rd;
      end
    end
  end
endmodule

/* File: bench/tb_flash_command_status_sequencer.sv */
// Purpose: Self-checking bench for the flash command sequencer host.
// Assumes: The flash model stands on the far side of the pins.
// Notes: Each scenario is one task that judges its own results.
`timescale 1ns/1ps
module tb_flash_command_status_sequencer
  import fcs_pkg::*;
;
  localparam logic [7:0] MK = 8'h5e;
  localparam logic [7:0] PT = 8'hc3;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_v;
  logic [AW-1:0] fl_addr;
  logic [DW-1:0] fl_dq_o;
  logic [DW-1:0] dq_out;
  logic [DW-1:0] dq_bus;
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, ready_busy_out;
  int fail_count = 0;
  int total_checks = 0;
  assign dq_bus = fl_dq_oe ? fl_dq_o : dq_out;

  fcs_top DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(dq_bus), .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .ready_busy_out(ready_busy_out));
  fcs_flash_model #(.MAKER(MK), .PART(PT)) M (.fl_addr(fl_addr), .dq_bus(dq_bus),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .dq_out(dq_out),
    .ready_busy_out(ready_busy_out));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_v = reg_rdata;
  endtask

  // Bounded wait on the busy flag; a hang counts as a mismatch.
  task automatic run(input logic [AW-1:0] a, input logic [7:0] d, input fcs_op_t op);
    wreg(R_ADDR, 32'(a));
    wreg(R_DATA, 32'(d));
    wreg(R_CTRL, 32'(op));
    rd_v = 32'h1;
    for (int i = 0; i < 3000 && rd_v[ST_BUSY] !== 1'b0; i++) rreg(R_STAT);
    chk(32'(rd_v[ST_BUSY]), 32'h0);
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [7:0] e);
    run(a, 8'h00, OP_READ);
    rreg(R_RES);
    chk(rd_v, 32'(e));
  endtask

  task automatic t_reset;
    rreg(R_STAT);
    chk(rd_v, 32'h20);
    rreg(8'h14);
    chk(rd_v, 32'h0);
  endtask

  task automatic t_prog;
    M.mem[22'h012345] = 8'h5a;
    rd_chk(22'h012345, 8'h5a);
    wreg(R_ADDR, 32'h020010);
    wreg(R_DATA, 32'h3c);
    wreg(R_CTRL, 32'(OP_PROG));
    repeat (60) @(posedge ref_clk);
    rreg(R_STAT);
    chk(32'({rd_v[ST_TOG], rd_v[ST_RDY], rd_v[ST_BUSY]}), 32'h5);
    wreg(R_CTRL, 32'(OP_READ));
    rreg(R_STAT);
    chk(32'(rd_v[ST_REFUSED]), 32'h1);
    run(22'h020010, 8'h3c, OP_NONE);
    rreg(R_STAT);
    chk(32'(rd_v[2:0]), 32'h2);
    rd_chk(22'h020010, 8'h3c);
  endtask

  task automatic t_prot;
    run(22'h3c0100, 8'h00, OP_PROG);
    rreg(R_STAT);
    chk(32'(rd_v[ST_FAIL]), 32'h1);
    rd_chk(22'h3c0100, 8'hff);
    run(22'h020010, 8'h80, OP_PROG);
    rreg(R_STAT);
    chk(32'(rd_v[2:0]), 32'h6);
    rd_chk(22'h020010, 8'h3c);
  endtask

  task automatic t_id;
    logic [AW-1:0] a [4] = '{22'h000000, 22'h000001, 22'h3c0002, 22'h000002};
    logic [7:0] e [4] = '{MK, PT, 8'h01, 8'h00};
    for (int i = 0; i < 4; i++) begin
      run(a[i], 8'h00, OP_ID);
      rreg(R_RES);
      chk(rd_v, 32'(e[i]));
    end
    rd_chk(22'h012345, 8'h5a);
  endtask

  task automatic t_sect;
    M.mem[22'h050004] = 8'h00;
    M.mem[22'h060000] = 8'h00;
    run(22'h050000, 8'h00, OP_SECT);
    rreg(R_STAT);
    chk(32'(rd_v[ST_WIN]), 32'h1);
    run(22'h060000, 8'h00, OP_ADDS);
    run(22'h050000, 8'h00, OP_SUSP);
    rreg(R_STAT);
    chk(32'({rd_v[ST_RDY], rd_v[2:0]}), 32'ha);
    run(22'h100000, 8'h11, OP_PROG);
    rreg(R_STAT);
    chk(32'(rd_v[2:0]), 32'h2);
    run(22'h050000, 8'h00, OP_RESUME);
    run(22'h050000, 8'h00, OP_POLL);
    rreg(R_STAT);
    chk(32'(rd_v[2:0]), 32'h2);
    rd_chk(22'h050004, 8'hff);
    rd_chk(22'h060000, 8'hff);
    rd_chk(22'h100000, 8'h11);
  endtask

  task automatic t_chip;
    M.mem[22'h200000] = 8'h00;
    M.mem[22'h3c0000] = 8'h00;
    run(22'h000000, 8'h00, OP_CHIP);
    rreg(R_STAT);
    chk(32'(rd_v[2:0]), 32'h2);
    rd_chk(22'h200000, 8'hff);
    rd_chk(22'h3c0000, 8'h00);
    run(22'h000000, 8'h00, OP_RESET);
    rreg(R_STAT);
    chk(32'(rd_v[2:0]), 32'h2);
    wreg(R_CTRL, 32'h0);
    rreg(R_STAT);
    chk(32'(rd_v[ST_REFUSED]), 32'h1);
    chk(32'(M.bad_cnt), 32'h0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #5000000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_prog();
    t_prot();
    t_id();
    t_sect();
    t_chip();
    tally_and_finish();
  end
endmodule
